// ==== sse_checker.sv ====
// sse_checker: port properties of the engine.
// assumes a bind to the engine top.
`timescale 1ns/100ps
`default_nettype none
module sse_checker (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] uset_out,
    input wire logic        output_on,
    input wire logic        run_active_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ************************************************************
    // properties
    // ************************************************************
    sequence s_go;
        psel && penable && pready && pwrite && paddr == sse_pkg::OFS_CMD && pwdata[0] && !run_active_flag;
    endsequence
    sequence s_stop;
        psel && penable && pready && pwrite && paddr == sse_pkg::OFS_CMD && pwdata[5] && run_active_flag;
    endsequence
    a_go_starts:
    assert property (s_go |-> ##[1:3] run_active_flag) else $error("run did not start");
    a_stop_ends:
    assert property (s_stop |-> ##[1:4] !run_active_flag) else $error("run did not end");
    a_on_at_start:
    assert property ($rose(run_active_flag) |-> output_on) else $error("output off at start");
    a_output_write:
    assert property (psel && penable && pready && pwrite && paddr == sse_pkg::OFS_OUTPUT
        |=> output_on == $past(pwdata[0])) else $error("output write lost");
    a_setpt_idle:
    assert property (!run_active_flag && $past(!run_active_flag) |-> $stable(uset_out))
        else $error("setpoint moved");
    a_read_cond:
    assert property (psel && !penable && !pwrite && paddr == sse_pkg::OFS_COND_A
        |=> prdata[7] == $past(run_active_flag)) else $error("busy bit wrong");
    a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready too long");
    a_unmapped_err:
    assert property (psel && !penable && paddr > sse_pkg::OFS_STATUS |=> pready && pslverr)
        else $error("unmapped not refused");
endmodule
bind sse_setpoint_sequence_engine sse_checker sse_checker_i (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .uset_out(uset_out), .output_on(output_on),
    .run_active_flag(run_active_flag));
`default_nettype wire

// ==== sse_pkg.sv ====
// sse_pkg: constants and types for the setpoint sequence engine.
// assumes a 20 MHz core clock and an APB master with 32-bit data.
package sse_pkg;

    // ************************************************************
    // step memory layout
    // ************************************************************
    localparam logic [7:0]  LOC_FIRST      = 8'h0b;
    localparam logic [7:0]  LOC_LAST       = 8'hff;
    localparam int unsigned SET_W          = 16;
    localparam int unsigned DWELL_W        = 14;
    localparam logic [13:0] DWELL_MAX      = 14'h270f;
    localparam logic [13:0] DWELL_ONE      = 14'h0001;

    typedef struct packed {
        logic               valid;
        logic               sig_flag;
        logic [DWELL_W-1:0] dwell;
        logic [SET_W-1:0]   iset;
        logic [SET_W-1:0]   uset;
    } sse_step_t;

    typedef enum {
        ST_IDLE,
        ST_SEEK,
        ST_RUN,
        ST_HOLD
    } sse_state_t;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned TICK_NS        = 10_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFS_CMD        = 12'h000;
    localparam logic [11:0] OFS_CFG        = 12'h004;
    localparam logic [11:0] OFS_DEF_DWELL  = 12'h008;
    localparam logic [11:0] OFS_OUTPUT     = 12'h00c;
    localparam logic [11:0] OFS_COND_A     = 12'h010;
    localparam logic [11:0] OFS_EVENT_A    = 12'h014;
    localparam logic [11:0] OFS_MEM_ADDR   = 12'h018;
    localparam logic [11:0] OFS_MEM_SET    = 12'h01c;
    localparam logic [11:0] OFS_MEM_CTL    = 12'h020;
    localparam logic [11:0] OFS_STATUS     = 12'h024;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned CMD_GO         = 0;
    localparam int unsigned CMD_SINGLE     = 1;
    localparam int unsigned CMD_HOLD       = 2;
    localparam int unsigned CMD_CONT       = 3;
    localparam int unsigned CMD_STEP       = 4;
    localparam int unsigned CMD_STOP       = 5;
    localparam int unsigned CFG_START_LSB  = 0;
    localparam int unsigned CFG_STOP_LSB   = 8;
    localparam int unsigned CFG_REP_LSB    = 16;
    localparam int unsigned CFG_STATUS_OUT_ONE       = 24;
    localparam int unsigned CFG_STATUS_OUT_TWO       = 25;
    localparam int unsigned RUN_FLAG_BIT   = 7;
    localparam int unsigned MEM_FLAG_BIT   = 14;
    localparam int unsigned MEM_VALID_BIT  = 15;
    localparam int unsigned STAT_REP_LSB   = 8;
    localparam int unsigned STAT_ST_LSB    = 16;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  RST_START      = 8'h0b;
    localparam logic [7:0]  RST_STOP       = 8'h0b;
    localparam logic [7:0]  RST_REPEAT     = 8'h01;
    localparam logic [13:0] RST_DEF_DWELL  = 14'h0064;

endpackage

// ==== sse_setpoint_sequence_engine.sv ====
// sse_setpoint_sequence_engine: step sequencer with APB register access.
// assumes one 20 MHz clock, an APB master, and a trigger pin from outside.
//
// What this block does
// - steps live at locations 11 to 255
// - run start switches power output on
// - output on/off writable during run, hold
// - halting never alters stored steps
// - valid last step keeps output on
// - empty last step, final pass: output off
// - run-active flag bit 7 condition A
// - run-done flag bit 7 event A
// - repeats 1 to 255, zero means endless
// - remaining repeats: jump back to first
// - automatic wrap decrements remaining repeats
// - single-step wrap keeps remaining repeats
// - empty locations are skipped
// - empty last step skipped while repeats remain
// - step dwell 0.01 to 99.99 s
// - default dwell 0.01 to 99.99 s
// - status signal lasts effective dwell
// - flag reaches output only if enabled
// - single-step ignores dwell, waits requests
// - run can hold and resume
// - status outputs active low, passive high
// - trigger falling edge steps, wraps first
`timescale 1ns/100ps
`default_nettype none

module sse_setpoint_sequence_engine #(
    parameter int unsigned TICK_CYCLES = sse_pkg::TICK_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        trig_in,
    output logic      [15:0] uset_out,
    output logic      [15:0] iset_out,
    output logic             output_on,
    output logic             run_active_flag,
    output logic             status_out_one_n,
    output logic             status_out_two_n
);

    // ************************************************************
    // reset release and trigger synchroniser
    // ************************************************************
    logic [1:0] rst_sr;
    logic       rst_sync_n;
    logic       trig_meta;
    logic       trig_sync;
    logic       trig_prev;
    logic       trig_fall;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sr <= 2'b00;
        end else begin
            rst_sr <= {rst_sr[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sr[1];

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= trig_in;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end
    assign trig_fall = trig_prev & ~trig_sync;

    // ************************************************************
    // configuration and step memory
    // ************************************************************
    sse_pkg::sse_step_t   mem [256];
    sse_pkg::sse_step_t   cur;
    sse_pkg::sse_state_t  state;
    logic [7:0]           start_addr;
    logic [7:0]           stop_addr;
    logic [7:0]           start_eff;
    logic [7:0]           stop_eff;
    logic [7:0]           repeat_count;
    logic                 status_out_one_follow;
    logic                 status_out_two_follow;
    logic [13:0]          default_dwell;
    logic [7:0]           mem_addr;
    logic [31:0]          mem_set;
    logic [7:0]           ptr;
    logic [7:0]           rrep;
    logic                 auto_mode;
    logic                 step_flag;
    logic [13:0]          dwell_left;
    logic                 run_done_flag;

    logic setup;
    logic wr;
    logic cmd_wr;
    logic cmd_go;
    logic cmd_single;
    logic cmd_hold;
    logic cmd_cont;
    logic cmd_step;
    logic cmd_stop;

    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pready & pwrite;
    assign cmd_wr = wr && (paddr == sse_pkg::OFS_CMD);
    assign cmd_go     = cmd_wr & pwdata[sse_pkg::CMD_GO];
    assign cmd_single = cmd_wr & pwdata[sse_pkg::CMD_SINGLE];
    assign cmd_hold   = cmd_wr & pwdata[sse_pkg::CMD_HOLD];
    assign cmd_cont   = cmd_wr & pwdata[sse_pkg::CMD_CONT];
    assign cmd_step   = cmd_wr & pwdata[sse_pkg::CMD_STEP];
    assign cmd_stop   = cmd_wr & pwdata[sse_pkg::CMD_STOP];

    // range kept inside 11..255, stop never before start
    assign start_eff = (start_addr < sse_pkg::LOC_FIRST) ? sse_pkg::LOC_FIRST : start_addr;
    assign stop_eff  = (stop_addr < start_eff) ? start_eff : stop_addr;
    assign cur       = mem[ptr];

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            start_addr    <= sse_pkg::RST_START;
            stop_addr     <= sse_pkg::RST_STOP;
            repeat_count  <= sse_pkg::RST_REPEAT;
            status_out_one_follow   <= 1'b0;
            status_out_two_follow   <= 1'b0;
            default_dwell <= sse_pkg::RST_DEF_DWELL;
            mem_addr      <= sse_pkg::LOC_FIRST;
            mem_set       <= 32'h0000_0000;
        end else if (wr) begin
            case (paddr)
                sse_pkg::OFS_CFG: begin
                    start_addr   <= pwdata[sse_pkg::CFG_START_LSB +: 8];
                    stop_addr    <= pwdata[sse_pkg::CFG_STOP_LSB +: 8];
                    repeat_count <= pwdata[sse_pkg::CFG_REP_LSB +: 8];
                    status_out_one_follow  <= pwdata[sse_pkg::CFG_STATUS_OUT_ONE];
                    status_out_two_follow  <= pwdata[sse_pkg::CFG_STATUS_OUT_TWO];
                end
                sse_pkg::OFS_DEF_DWELL: begin
                    if (pwdata[13:0] == 14'h0000) begin
                        default_dwell <= sse_pkg::DWELL_ONE;
                    end else if (pwdata[13:0] > sse_pkg::DWELL_MAX) begin
                        default_dwell <= sse_pkg::DWELL_MAX;
                    end else begin
                        default_dwell <= pwdata[13:0];
                    end
                end
                sse_pkg::OFS_MEM_ADDR: begin
                    mem_addr <= pwdata[7:0];
                end
                sse_pkg::OFS_MEM_SET: begin
                    mem_set <= pwdata;
                end
                default: begin
                end
            endcase
        end
    end

    // memory has no reset: contents are whatever software last stored
    // only software writes touch the step memory
    always_ff @(posedge core_clk) begin
        if (wr && paddr == sse_pkg::OFS_MEM_CTL && mem_addr >= sse_pkg::LOC_FIRST) begin
            mem[mem_addr].valid    <= pwdata[sse_pkg::MEM_VALID_BIT];
            mem[mem_addr].sig_flag <= pwdata[sse_pkg::MEM_FLAG_BIT];
            // step dwell limited to 99.99 s
            mem[mem_addr].dwell    <= (pwdata[13:0] > sse_pkg::DWELL_MAX) ? sse_pkg::DWELL_MAX : pwdata[13:0];
            mem[mem_addr].iset     <= mem_set[31:16];
            mem[mem_addr].uset     <= mem_set[15:0];
        end
    end

    // ************************************************************
    // 10 ms time base
    // ************************************************************
    logic [31:0] tick_cnt;
    logic        tick;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    logic step_load;
    logic at_stop;
    logic wrap_ok;
    logic advance;
    logic empty_stop;
    logic finish_off;
    logic start_req;

    assign start_req  = (state == sse_pkg::ST_IDLE) && (cmd_go || cmd_single);
    // seek loads the first valid location
    assign step_load  = (state == sse_pkg::ST_SEEK) && !cmd_stop && cur.valid;
    assign at_stop    = (ptr == stop_eff);
    // single-step always wraps; zero repeats endless
    assign wrap_ok    = !auto_mode || (repeat_count == 8'h00) || (rrep > 8'h01);
    assign empty_stop = (state == sse_pkg::ST_SEEK) && !cmd_stop && !cur.valid && at_stop;
    // empty last step on final pass
    assign finish_off = empty_stop && !wrap_ok;
    assign advance    = ((state == sse_pkg::ST_RUN) && !cmd_stop && !cmd_hold && tick
                         && dwell_left == sse_pkg::DWELL_ONE)
                      || ((state == sse_pkg::ST_HOLD) && !cmd_stop && (cmd_cont || cmd_step || trig_fall));

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state     <= sse_pkg::ST_IDLE;
            ptr       <= sse_pkg::LOC_FIRST;
            rrep      <= sse_pkg::RST_REPEAT;
            auto_mode <= 1'b0;
        end else begin
            case (state)
                sse_pkg::ST_IDLE: begin
                    if (start_req) begin
                        state     <= sse_pkg::ST_SEEK;
                        ptr       <= start_eff;
                        rrep      <= repeat_count;
                        auto_mode <= cmd_go;
                    end
                end
                sse_pkg::ST_SEEK: begin
                    if (cmd_stop) begin
                        state <= sse_pkg::ST_IDLE;
                    end else if (cur.valid) begin
                        state <= auto_mode ? sse_pkg::ST_RUN : sse_pkg::ST_HOLD;
                    end else if (at_stop) begin
                        // empty last step skipped while repeats remain
                        if (wrap_ok) begin
                            ptr <= start_eff;
                            if (auto_mode && repeat_count != 8'h00) begin
                                rrep <= rrep - 8'h01;
                            end
                        end else begin
                            state <= sse_pkg::ST_IDLE;
                        end
                    end else begin
                        ptr <= ptr + 8'h01;
                    end
                end
                sse_pkg::ST_RUN,
                sse_pkg::ST_HOLD: begin
                    if (cmd_stop) begin
                        state <= sse_pkg::ST_IDLE;
                    end else if (state == sse_pkg::ST_RUN && cmd_hold) begin
                        state <= sse_pkg::ST_HOLD;
                    end else if (advance) begin
                        if (state == sse_pkg::ST_HOLD && cmd_cont) begin
                            auto_mode <= 1'b1;
                        end
                        if (!at_stop) begin
                            ptr   <= ptr + 8'h01;
                            state <= sse_pkg::ST_SEEK;
                        end else if (wrap_ok || (state == sse_pkg::ST_HOLD && !cmd_cont)) begin
                            ptr   <= start_eff;
                            state <= sse_pkg::ST_SEEK;
                            if (auto_mode && state == sse_pkg::ST_RUN && repeat_count != 8'h00) begin
                                rrep <= rrep - 8'h01;
                            end
                        end else begin
                            // valid last step: setpoints stay applied
                            state <= sse_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= sse_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dwell_left <= 14'h0000;
            step_flag  <= 1'b0;
            uset_out   <= 16'h0000;
            iset_out   <= 16'h0000;
        end else if (step_load) begin
            dwell_left <= (cur.dwell == 14'h0000) ? default_dwell : cur.dwell;
            step_flag  <= cur.sig_flag;
            uset_out   <= cur.uset;
            iset_out   <= cur.iset;
        end else if (state == sse_pkg::ST_IDLE) begin
            dwell_left <= 14'h0000;
            step_flag  <= 1'b0;
        end else if (tick && dwell_left != 14'h0000 && state != sse_pkg::ST_HOLD) begin
            dwell_left <= dwell_left - sse_pkg::DWELL_ONE;
        end else if (tick && dwell_left != 14'h0000 && !auto_mode) begin
            // single-step still times the status signal
            dwell_left <= dwell_left - sse_pkg::DWELL_ONE;
        end
    end

    // ************************************************************
    // power output, flags and status outputs
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            output_on <= 1'b0;
        end else if (start_req) begin
            output_on <= 1'b1;
        end else if (finish_off) begin
            // output off on empty last step
            output_on <= 1'b0;
        end else if (wr && paddr == sse_pkg::OFS_OUTPUT) begin
            output_on <= pwdata[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_active_flag  <= 1'b0;
            run_done_flag    <= 1'b0;
            status_out_one_n <= 1'b1;
            status_out_two_n <= 1'b1;
        end else begin
            run_active_flag <= (state != sse_pkg::ST_IDLE);
            // done on return to idle; set beats clear
            if (run_active_flag && state == sse_pkg::ST_IDLE) begin
                run_done_flag <= 1'b1;
            end else if (wr && paddr == sse_pkg::OFS_EVENT_A && pwdata[sse_pkg::RUN_FLAG_BIT]) begin
                run_done_flag <= 1'b0;
            end
            // active low for the effective dwell
            status_out_one_n <= ~(status_out_one_follow & step_flag & (dwell_left != 14'h0000));
            status_out_two_n <= ~(status_out_two_follow & step_flag & (dwell_left != 14'h0000));
        end
    end

    // ************************************************************
    // APB slave: zero wait states, read data captured in setup
    // ************************************************************
    logic [31:0] rdata;
    logic        hit;

    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (paddr)
            sse_pkg::OFS_CMD: begin
                rdata = 32'h0000_0000;
            end
            sse_pkg::OFS_CFG: begin
                rdata = {6'h00, status_out_two_follow, status_out_one_follow, repeat_count, stop_addr, start_addr};
            end
            sse_pkg::OFS_DEF_DWELL: begin
                rdata = {18'h0_0000, default_dwell};
            end
            sse_pkg::OFS_OUTPUT: begin
                rdata = {31'h0000_0000, output_on};
            end
            sse_pkg::OFS_COND_A: begin
                rdata[sse_pkg::RUN_FLAG_BIT] = run_active_flag;
            end
            sse_pkg::OFS_EVENT_A: begin
                rdata[sse_pkg::RUN_FLAG_BIT] = run_done_flag;
            end
            sse_pkg::OFS_MEM_ADDR: begin
                rdata = {24'h00_0000, mem_addr};
            end
            sse_pkg::OFS_MEM_SET: begin
                rdata = mem_set;
            end
            sse_pkg::OFS_MEM_CTL: begin
                rdata = {16'h0000, mem[mem_addr].valid, mem[mem_addr].sig_flag, mem[mem_addr].dwell};
            end
            sse_pkg::OFS_STATUS: begin
                rdata[7:0]                         = ptr;
                rdata[sse_pkg::STAT_REP_LSB +: 8]  = rrep;
                rdata[sse_pkg::STAT_ST_LSB +: 2]   = 2'(state);
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata <= rdata;
            end
        end
    end

endmodule

`default_nettype wire

// ==== sse_setpoint_sequence_engine_bench.sv ====
// sse_setpoint_sequence_engine_bench: apb scenarios.
// assumes package, engine, checker, model compile first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t mismatch", $time); end end
`define WT(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge core_clk); n++; end if (n >= 3000) tmo(); end
module sse_setpoint_sequence_engine_bench;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rq;
    logic [15:0] uset_out, iset_out;
    logic        pready, pslverr, err, trig_in, trig_req = 1'b0;
    logic        output_on, run_active_flag, sig_one_n, sig_two_n;
    int          fails = 0, total_checks = 0, n;
    always #25 core_clk = ~core_clk;
    sse_setpoint_sequence_engine #(.TICK_CYCLES(4)) sse_setpoint_sequence_engine_i (.core_clk(core_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .uset_out(uset_out),
        .iset_out(iset_out), .output_on(output_on), .run_active_flag(run_active_flag),
        .status_out_one_n(sig_one_n), .status_out_two_n(sig_two_n));
    sse_stage_model sse_stage_model_i (.core_clk(core_clk), .trig_req(trig_req), .trig_in(trig_in));
    task automatic final_report;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tmo;
        fails++;
        $display("[ERR] %0t timeout", $time);
        final_report();
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) tmo();
        rq = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic mem(input logic [7:0] l, input logic [31:0] s, input logic [31:0] c);
        wr(sse_pkg::OFS_MEM_ADDR, {24'h00_0000, l});
        wr(sse_pkg::OFS_MEM_SET, s);
        wr(sse_pkg::OFS_MEM_CTL, c);
    endtask
    task automatic pulse;
        @(posedge core_clk);
        trig_req <= 1'b1;
        @(posedge core_clk);
        trig_req <= 1'b0;
    endtask
    initial begin
        repeat (90000) @(posedge core_clk);
        tmo();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(sse_pkg::OFS_CFG);
        `CHK(rq, 32'h0001_0b0b)
        rd(sse_pkg::OFS_DEF_DWELL);
        `CHK(rq, 32'h0000_0064)
        rd(12'h028);
        `CHK({err, rq}, {1'b1, 32'h0000_0000})
        mem(8'h0b, 32'h0000_0000, 32'h0000_0000);
        mem(8'h0c, 32'h0010_0100, 32'h0000_c000);
        mem(8'h0d, 32'h0000_0000, 32'h0000_0000);
        mem(8'h0e, 32'h0020_0200, 32'h0000_8002);
        wr(sse_pkg::OFS_DEF_DWELL, 32'h0000_0003);
        wr(sse_pkg::OFS_CFG, 32'h0102_0e0b);
        // ************************************************************
        // automatic run, two passes
        // ************************************************************
        wr(sse_pkg::OFS_CMD, 32'h0000_0001);
        `WT(uset_out === 16'h0100)
        repeat (2) @(posedge core_clk);
        `CHK(output_on, 1'b1)
        `CHK({sig_one_n, sig_two_n}, 2'b01)
        wr(sse_pkg::OFS_CMD, 32'h0000_0004);
        rd(sse_pkg::OFS_STATUS);
        `CHK(rq, 32'h0003_020c)
        wr(sse_pkg::OFS_CMD, 32'h0000_0008);
        `WT(uset_out === 16'h0200)
        repeat (2) @(posedge core_clk);
        `CHK(sig_one_n, 1'b1)
        `WT(uset_out === 16'h0100)
        rd(sse_pkg::OFS_STATUS);
        `CHK(rq[15:8], 8'h01)
        `WT(run_active_flag === 1'b0)
        `CHK({output_on, iset_out, uset_out}, {1'b1, 16'h0020, 16'h0200})
        rd(sse_pkg::OFS_EVENT_A);
        `CHK(rq[7], 1'b1)
        wr(sse_pkg::OFS_MEM_ADDR, 32'h0000_000e);
        rd(sse_pkg::OFS_MEM_CTL);
        `CHK(rq, 32'h0000_8002)
        // ************************************************************
        // single step, then empty last step
        // ************************************************************
        wr(sse_pkg::OFS_CMD, 32'h0000_0002);
        `WT(uset_out === 16'h0100)
        pulse();
        `WT(uset_out === 16'h0200)
        repeat (60) @(posedge core_clk);
        `CHK(uset_out, 16'h0200)
        pulse();
        `WT(uset_out === 16'h0100)
        rd(sse_pkg::OFS_STATUS);
        `CHK(rq, 32'h0003_020c)
        wr(sse_pkg::OFS_OUTPUT, 32'h0000_0000);
        @(posedge core_clk);
        `CHK(output_on, 1'b0)
        wr(sse_pkg::OFS_CMD, 32'h0000_0020);
        `WT(run_active_flag === 1'b0)
        wr(sse_pkg::OFS_CFG, 32'h0001_0d0c);
        wr(sse_pkg::OFS_CMD, 32'h0000_0001);
        `WT(run_active_flag === 1'b1)
        rd(sse_pkg::OFS_COND_A);
        `CHK(rq[7], 1'b1)
        `WT(run_active_flag === 1'b0)
        `CHK(output_on, 1'b0)
        final_report();
    end
endmodule
`default_nettype wire

// ==== sse_stage_model.sv ====
// sse_stage_model: far side, makes trigger pulses on request.
// assumes trig_req is a one-cycle pulse from the bench.
`timescale 1ns/100ps
`default_nettype none
module sse_stage_model (
    input  wire logic core_clk,
    input  wire logic trig_req,
    output logic      trig_in
);
    logic [3:0] width_cnt = 4'h0;
    // long pulse for the pin synchroniser
    always_ff @(posedge core_clk) begin
        if (trig_req) begin
            width_cnt <= 4'h8;
        end else if (width_cnt != 4'h0) begin
            width_cnt <= width_cnt - 4'h1;
        end
    end
    assign trig_in = (width_cnt != 4'h0);
endmodule
`default_nettype wire
